// file: logic/digital_io_pattern_interrupt.sv
// Sixteen-line digital I/O with pattern, event and strobe interrupts
`timescale 1ns/1ns
module digital_io_pattern_interrupt (
    input  wire logic                    clk,          // 25 MHz clock
    input  wire logic                    srst,         // Synchronous reset
    input  wire dio_pattern_pkg::io_req_t ioReq,       // Host I/O cycle
    output logic [7:0]                   ioRdData,     // Read data, one cycle after rd
    input  wire logic [7:0]              bitPortIn,    // Bit port pin levels
    output logic [7:0]                   bitPortOut,   // Bit port drive values
    output logic [7:0]                   bitPortOeN,   // Low where bit port drives
    input  wire logic [7:0]              bytePortIn,   // Byte port pin levels
    output logic [7:0]                   bytePortOut,  // Byte port drive values
    output logic                         bytePortOeN,  // Low while byte port drives
    input  wire logic                    strobeIn,     // Strobe pin
    input  wire logic                    standby,      // System in standby
    output logic                         irqReq,       // Interrupt request
    output logic                         wakeReq       // Wake event request
);
    import dio_pattern_pkg::*;

    // Bits that differ from the compare and survive the mask
    function automatic logic [7:0] unmaskedDiff(input logic [7:0] a, input logic [7:0] b,
                                                input logic [7:0] ign);
        unmaskedDiff = (a ^ b) & ~ign;
    endfunction : unmaskedDiff

    // Address match with a strobe
    function automatic logic hit(input logic stb, input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] t);
        hit = stb & (a == t);
    endfunction : hit

    // Synchronisers: first and second stages
    logic [7:0]        bitMeta, bitSync;    // Bit port pins
    logic [7:0]        byteMeta, byteSync;  // Byte port pins
    logic              strbMeta, strbSync;  // Strobe pin
    logic              sbyMeta, sbySync;    // Standby level
    logic              strbLast;            // Strobe level one cycle back

    // Register state
    logic [7:0]        bitData;             // Bit port output latch
    logic [7:0]        byteData;            // Byte port output latch
    logic [7:0]        pinDirection;        // One = output
    logic [7:0]        patternIgnore;       // Mask register
    logic [7:0]        patternLatch;        // Compare register
    ctrl_t             ctrl;                // Mode, byte direction, selector
    logic              statusFlag;          // Detection status, control bit 6
    logic [1:0]        wakeControl;         // Int mask and wake enable
    logic              pending;             // Held interrupt request
    logic              strobeArmed;         // Strobe may be accepted
    logic [TICK_W-1:0] tickCnt;             // Sample divider
    logic              tick;                // Sample strobe

    // Decoded accesses
    logic              wrBit, wrByte, wrWin, wrCtrl, wrWake;
    logic              rdWin;
    logic              clearWrite, clearRead, compareRead, compareWrite;
    logic              strobeRise, strobeHit;
    logic              compareOn, detect, sampleLoad;
    logic [7:0]        diff;
    logic [7:0]        bitRead;

    assign wrBit        = hit(ioReq.wr, ioReq.addr, BIT_PORT_ADDR);
    assign wrByte       = hit(ioReq.wr, ioReq.addr, BYTE_PORT_ADDR);
    assign wrWin        = hit(ioReq.wr, ioReq.addr, WINDOW_ADDR);
    assign wrCtrl       = hit(ioReq.wr, ioReq.addr, CONTROL_ADDR);
    assign wrWake       = hit(ioReq.wr, ioReq.addr, WAKE_ADDR);
    assign rdWin        = hit(ioReq.rd, ioReq.addr, WINDOW_ADDR);
    // Window function picked by the selector
    assign clearWrite   = wrWin && ctrl.sel == SEL_CLEAR;
    assign clearRead    = rdWin && ctrl.sel == SEL_CLEAR;
    assign compareRead  = rdWin && ctrl.sel == SEL_COMPARE;
    assign compareWrite = wrWin && ctrl.sel == SEL_COMPARE;

    // Two-flop synchronisers on every pin input
    always_ff @(posedge clk) begin
        bitMeta  <= bitPortIn;
        bitSync  <= bitMeta;
        byteMeta <= bytePortIn;
        byteSync <= byteMeta;
        strbMeta <= strobeIn;
        strbSync <= strbMeta;
        sbyMeta  <= standby;
        sbySync  <= sbyMeta;
    end

    // Strobe edge history
    always_ff @(posedge clk) begin
        if (srst) begin
            strbLast <= 1'b0;
        end else begin
            strbLast <= strbSync;
        end
    end
    assign strobeRise = strbSync & ~strbLast;

    // Sample divider: 8.33 MHz normally, 32 kHz in standby
    always_ff @(posedge clk) begin
        if (srst) begin
            tickCnt <= '0;
        end else if (tick) begin
            tickCnt <= '0;
        end else begin
            tickCnt <= tickCnt + 1'b1;
        end
    end
    assign tick = sbySync ? (tickCnt >= STANDBY_LAST)
                          : (tickCnt >= SAMPLE_LAST);

    // Comparator and detection
    assign compareOn  = patternIgnore != ALL_ONES;
    assign diff       = unmaskedDiff(bitSync, patternLatch, patternIgnore);
    // Only event mode reloads the compare on sample ticks; match must keep the software pattern
    assign sampleLoad = tick && ctrl.mode == MODE_EVENT;
    assign strobeHit  = ctrl.mode == MODE_STROBE && strobeRise && strobeArmed;
    always_comb begin
        detect = 1'b0;
        unique case (ctrl.mode)
            MODE_EVENT:  detect = tick && compareOn && diff != ZERO_BYTE;
            MODE_MATCH:  detect = tick && compareOn && diff == ZERO_BYTE;
            MODE_STROBE: detect = strobeHit;
            MODE_OFF:    detect = 1'b0;
        endcase
    end

    // Bit port output latch
    always_ff @(posedge clk) begin
        if (srst || clearWrite) begin
            bitData <= ZERO_BYTE;
        end else if (wrBit) begin
            bitData <= ioReq.wrData;
        end
    end

    // Byte port output latch
    always_ff @(posedge clk) begin
        if (srst || clearWrite) begin
            byteData <= ZERO_BYTE;
        end else if (wrByte) begin
            byteData <= ioReq.wrData;
        end
    end

    // Direction register
    always_ff @(posedge clk) begin
        if (srst) begin
            pinDirection <= ZERO_BYTE;
        end else if (wrWin && ctrl.sel == SEL_DIR) begin
            pinDirection <= ioReq.wrData;
        end
    end

    // Mask register
    always_ff @(posedge clk) begin
        if (srst || clearWrite) begin
            patternIgnore <= ZERO_BYTE;
        end else if (wrWin && ctrl.sel == SEL_MASK) begin
            patternIgnore <= ioReq.wrData;
        end
    end

    // Compare register: software, sampling or strobe capture
    always_ff @(posedge clk) begin
        if (srst || clearWrite) begin
            patternLatch <= ZERO_BYTE;
        end else if (compareWrite) begin
            patternLatch <= ioReq.wrData;
        end else if (sampleLoad) begin
            patternLatch <= bitSync;
        end else if (strobeHit) begin
            patternLatch <= bitSync;
        end
    end

    // Strobe lock, released by a compare read
    always_ff @(posedge clk) begin
        if (srst) begin
            strobeArmed <= 1'b1;
        end else if (compareRead) begin
            strobeArmed <= 1'b1;
        end else if (strobeHit) begin
            strobeArmed <= 1'b0;
        end
    end

    // Control register writable fields
    always_ff @(posedge clk) begin
        if (srst || clearWrite) begin
            ctrl <= '0;
        end else if (wrCtrl) begin
            ctrl.sel     <= window_sel_t'(ioReq.wrData[CTRL_SEL_LO +: 2]);
            ctrl.byteOut <= ioReq.wrData[CTRL_BYTE_DIR];
            ctrl.mode    <= irq_mode_t'(ioReq.wrData[CTRL_MODE_LO +: 2]);
        end
    end

    // Status flag: detection wins over any clear
    always_ff @(posedge clk) begin
        if (srst) begin
            statusFlag <= 1'b0;
        end else if (detect) begin
            statusFlag <= 1'b1;
        end else if (clearRead || clearWrite) begin
            statusFlag <= 1'b0;
        end
    end

    // Held interrupt request: set wins over clear read
    always_ff @(posedge clk) begin
        if (srst) begin
            pending <= 1'b0;
        end else if (detect) begin
            pending <= 1'b1;
        end else if (clearRead) begin
            pending <= 1'b0;
        end
    end

    // Wake control register
    always_ff @(posedge clk) begin
        if (srst) begin
            wakeControl <= 2'b00;
        end else if (wrWake) begin
            wakeControl <= {ioReq.wrData[WAKE_INT_MASK], ioReq.wrData[WAKE_ENABLE]};
        end
    end

    // Interrupt and wake outputs
    always_ff @(posedge clk) begin
        if (srst) begin
            irqReq  <= 1'b0;
            wakeReq <= 1'b0;
        end else begin
            irqReq  <= pending & ~wakeControl[WAKE_INT_MASK];
            wakeReq <= pending & wakeControl[WAKE_ENABLE];
        end
    end

    // Pin drivers, enables low while driving
    always_ff @(posedge clk) begin
        if (srst) begin
            bitPortOut  <= ZERO_BYTE;
            bitPortOeN  <= ALL_ONES;
            bytePortOut <= ZERO_BYTE;
            bytePortOeN <= 1'b1;
        end else begin
            bitPortOut  <= bitData;
            bitPortOeN  <= ~pinDirection;
            bytePortOut <= byteData;
            bytePortOeN <= ~ctrl.byteOut;
        end
    end

    // Per-bit read source of the bit port
    generate
        for (genvar i = 0; i < 8; i++) begin : gBitRead
            assign bitRead[i] = pinDirection[i] ? bitData[i] : bitSync[i];
        end
    endgenerate

    // Read data, one cycle after the read strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            ioRdData <= ZERO_BYTE;
        end else if (ioReq.rd) begin
            ioRdData <= ZERO_BYTE;
            unique case (ioReq.addr)
                BIT_PORT_ADDR:  ioRdData <= bitRead;
                BYTE_PORT_ADDR: ioRdData <= ctrl.byteOut ? byteData : byteSync;
                WINDOW_ADDR:    ioRdData <= (ctrl.sel == SEL_COMPARE) ? patternLatch
                                                                      : ZERO_BYTE;
                CONTROL_ADDR:   ioRdData <= {1'b0, statusFlag, 1'b0, ctrl};
                WAKE_ADDR:      ioRdData <= {6'h00, wakeControl};
                default:        ioRdData <= ZERO_BYTE;
            endcase
        end
    end

    // Checks
    AST_CLEAR_ZEROES: assert property (@(posedge clk) disable iff (srst)
        clearWrite |=> (patternLatch == ZERO_BYTE && patternIgnore == ZERO_BYTE &&
                        bitData == ZERO_BYTE && byteData == ZERO_BYTE &&
                        ctrl.mode == MODE_OFF))
        else $error("clear write left a register nonzero");

    AST_CLEAR_READ: assert property (@(posedge clk) disable iff (srst)
        (clearRead && !detect) |=> !pending ##1 !irqReq)
        else $error("clear read did not drop the request");

    AST_MASK_ALL: assert property (@(posedge clk) disable iff (srst)
        (patternIgnore == ALL_ONES && ctrl.mode != MODE_STROBE) |-> !detect)
        else $error("detection with all mask bits set");

    AST_STROBE_CAPTURE: assert property (@(posedge clk) disable iff (srst)
        (strobeHit && !clearWrite && !compareWrite) |=>
            (patternLatch == $past(bitSync) && !strobeArmed))
        else $error("strobe did not capture the port");

    AST_STROBE_LOCK: assert property (@(posedge clk) disable iff (srst)
        (!strobeArmed && !compareRead) |=> !strobeArmed)
        else $error("strobe lock released without compare read");

    AST_HELD: assert property (@(posedge clk) disable iff (srst)
        (pending && !clearRead) |=> pending ##1 (irqReq || $past(wakeControl[WAKE_INT_MASK])))
        else $error("request dropped without a clear read");

    AST_EVENT: assert property (@(posedge clk) disable iff (srst)
        (ctrl.mode == MODE_EVENT && tick && compareOn && diff != ZERO_BYTE) |=>
            (pending && statusFlag))
        else $error("event change not flagged");

    AST_MATCH: assert property (@(posedge clk) disable iff (srst)
        (ctrl.mode == MODE_MATCH && tick && compareOn && diff == ZERO_BYTE) |=>
            (pending && statusFlag))
        else $error("pattern match not flagged");

    AST_SAMPLE_RATE: assert property (@(posedge clk) disable iff (srst)
        (tick && !sbySync) |=> !tick [*2] ##1 (tick || sbySync))
        else $error("sampling period is not three cycles");

    AST_WAKE: assert property (@(posedge clk) disable iff (srst)
        (pending && wakeControl[WAKE_ENABLE]) |=> wakeReq)
        else $error("wake not raised");
endmodule : digital_io_pattern_interrupt

// file: logic/dio_pattern_pkg.sv
// Constants and carrier types for the pattern-interrupt digital I/O block
package dio_pattern_pkg;
    // Clock and sampling timing
    localparam int CLK_NS            = 40;        // Main clock period, 25 MHz
    localparam int SAMPLE_NS         = 120;       // Normal sampling period, about 8.33 MHz
    localparam int STANDBY_SAMPLE_NS = 30518;     // Standby sampling period, about 32 kHz
    localparam int SAMPLE_CYC        = (SAMPLE_NS / CLK_NS < 1) ? 1 : SAMPLE_NS / CLK_NS;
    localparam int STANDBY_CYC       = STANDBY_SAMPLE_NS / CLK_NS;
    localparam int TICK_W            = 10;        // Width of the sample divider
    localparam logic [TICK_W-1:0] SAMPLE_LAST  = TICK_W'(SAMPLE_CYC - 1);
    localparam logic [TICK_W-1:0] STANDBY_LAST = TICK_W'(STANDBY_CYC - 1);

    // I/O addresses (10-bit I/O space)
    localparam int ADDR_W = 10;
    localparam logic [ADDR_W-1:0] BIT_PORT_ADDR  = 10'h450;
    localparam logic [ADDR_W-1:0] BYTE_PORT_ADDR = 10'h451;
    localparam logic [ADDR_W-1:0] WINDOW_ADDR    = 10'h452;
    localparam logic [ADDR_W-1:0] CONTROL_ADDR   = 10'h453;
    localparam logic [ADDR_W-1:0] WAKE_ADDR      = 10'h454;

    // Control register field positions
    localparam int CTRL_SEL_LO   = 0;             // Window selector, bits 1:0
    localparam int CTRL_BYTE_DIR = 2;             // Byte port direction, 1 = output
    localparam int CTRL_MODE_LO  = 3;             // Mode field, bits 4:3
    localparam int CTRL_STATUS   = 6;             // Detection status flag
    // Wake control field positions
    localparam int WAKE_ENABLE   = 0;
    localparam int WAKE_INT_MASK = 1;

    // Reset and fill values
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ALL_ONES  = 8'hff;

    // Window function selector
    typedef enum logic [1:0] {
        SEL_CLEAR   = 2'b00,
        SEL_DIR     = 2'b01,
        SEL_MASK    = 2'b10,
        SEL_COMPARE = 2'b11
    } window_sel_t;

    // Interrupt mode field
    typedef enum logic [1:0] {
        MODE_OFF    = 2'b00,
        MODE_STROBE = 2'b01,
        MODE_EVENT  = 2'b10,
        MODE_MATCH  = 2'b11
    } irq_mode_t;

    // Host I/O cycle request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wrData;
        logic              rd;
        logic              wr;
    } io_req_t;

    // Writable part of the control register
    typedef struct packed {
        irq_mode_t   mode;
        logic        byteOut;
        window_sel_t sel;
    } ctrl_t;
endpackage : dio_pattern_pkg

// file: sim/dio_pins_model.sv
// Behavioural model of the external lines on the connector side
`timescale 1ns/1ns
module dio_pins_model (
    input  wire logic [7:0] extBit,       // Level the outside world puts on bit lines
    input  wire logic [7:0] extByte,      // Level the outside world puts on byte lines
    input  wire logic       extStrobe,    // Outside strobe level
    input  wire logic [7:0] bitPortOut,   // Device drive values, bit port
    input  wire logic [7:0] bitPortOeN,   // Low where the device drives a bit line
    input  wire logic [7:0] bytePortOut,  // Device drive value, byte port
    input  wire logic       bytePortOeN,  // Low while the device drives the byte
    output logic [7:0]      bitPins,      // Resolved bit line levels
    output logic [7:0]      bytePins,     // Resolved byte line levels
    output logic            strobePin     // Resolved strobe line
);
    // Device wins on lines it drives, outside levels elsewhere
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            bitPins[i] = bitPortOeN[i] ? extBit[i] : bitPortOut[i];
        end
        bytePins  = bytePortOeN ? extByte : bytePortOut;
        strobePin = extStrobe;
    end
endmodule : dio_pins_model

// file: sim/testbench.sv
// Self-checking bench for the pattern-interrupt digital I/O block
`timescale 1ns/1ns
module testbench;
    import dio_pattern_pkg::*;
    logic       clk;                   // 25 MHz clock
    logic       srst;                  // Synchronous reset
    io_req_t    ioReq;                 // Host cycle
    logic [7:0] ioRdData;              // Read data
    logic [7:0] bitPins;               // Bit line levels
    logic [7:0] bitPortOut;            // Bit drive values
    logic [7:0] bitPortOeN;            // Bit drive enables
    logic [7:0] bytePins;              // Byte line levels
    logic [7:0] bytePortOut;           // Byte drive value
    logic       bytePortOeN;           // Byte drive enable
    logic       strobePin;             // Strobe line
    logic       standby;               // Standby request
    logic       irqReq;                // Interrupt request
    logic       wakeReq;               // Wake request
    logic [7:0] extBit;                // Outside bit levels
    logic [7:0] extByte;               // Outside byte levels
    logic       extStrobe;             // Outside strobe
    int         err_count;             // Mismatches
    int         checks;                // Comparisons

    digital_io_pattern_interrupt u_dut (.clk(clk), .srst(srst), .ioReq(ioReq),
        .ioRdData(ioRdData), .bitPortIn(bitPins), .bitPortOut(bitPortOut),
        .bitPortOeN(bitPortOeN), .bytePortIn(bytePins), .bytePortOut(bytePortOut),
        .bytePortOeN(bytePortOeN), .strobeIn(strobePin), .standby(standby),
        .irqReq(irqReq), .wakeReq(wakeReq));

    dio_pins_model u_pins (.extBit(extBit), .extByte(extByte), .extStrobe(extStrobe),
        .bitPortOut(bitPortOut), .bitPortOeN(bitPortOeN), .bytePortOut(bytePortOut),
        .bytePortOeN(bytePortOeN), .bitPins(bitPins), .bytePins(bytePins),
        .strobePin(strobePin));

    // Clock generator
    always #20 clk = ~clk;

    // Wait whole cycles, then step off the edge
    task idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : idle

    // Byte comparison
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One-cycle write strobe, result settled afterwards
    task wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk);
        ioReq <= '{addr: a, wrData: d, rd: 1'b0, wr: 1'b1};
        @(posedge clk);
        ioReq.wr <= 1'b0;
        idle(1);
    endtask : wr

    // One-cycle read strobe, data taken a cycle later
    task rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge clk);
        ioReq <= '{addr: a, wrData: 8'h00, rd: 1'b1, wr: 1'b0};
        @(posedge clk);
        ioReq.rd <= 1'b0;
        idle(1);
        d = ioRdData;
    endtask : rd

    // Read and compare
    task rd_chk(input logic [9:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(d, exp);
    endtask : rd_chk

    // Board clear, wake off, pending dropped by a clear read
    task clear_all;
        logic [7:0] d;
        wr(CONTROL_ADDR, 8'h00);
        wr(WINDOW_ADDR, 8'h00);
        wr(WAKE_ADDR, 8'h00);
        rd(WINDOW_ADDR, d);
    endtask : clear_all

    // Strobe pulse of four cycles, then time to land
    task pulse;
        @(posedge clk);
        extStrobe <= 1'b1;
        repeat (4) @(posedge clk);
        extStrobe <= 1'b0;
        idle(8);
    endtask : pulse

    // Direction, port data and board clear
    task test_ports;
        wr(CONTROL_ADDR, 8'h01);
        wr(WINDOW_ADDR, 8'hf0);
        wr(BIT_PORT_ADDR, 8'ha5);
        @(posedge clk);
        extBit  <= 8'h3c;
        extByte <= 8'h5a;
        idle(4);
        rd_chk(BIT_PORT_ADDR, 8'hac);
        chk(bitPortOeN, 8'h0f);
        chk(bitPortOut & 8'hf0, 8'ha0);
        rd_chk(BYTE_PORT_ADDR, 8'h5a);
        wr(CONTROL_ADDR, 8'h04);
        wr(BYTE_PORT_ADDR, 8'h99);
        chk({7'h00, bytePortOeN}, 8'h00);
        chk(bytePortOut, 8'h99);
        rd_chk(BYTE_PORT_ADDR, 8'h99);
        wr(WINDOW_ADDR, 8'h00);
        rd_chk(CONTROL_ADDR, 8'h00);
        chk({7'h00, bytePortOeN}, 8'h01);
        chk(bitPortOut, 8'h00);
        rd_chk(BIT_PORT_ADDR, 8'h0c);
    endtask : test_ports

    // Match mode, status, holding, disable, wake and interrupt mask
    task test_match;
        logic [7:0] d;
        clear_all();
        wr(CONTROL_ADDR, 8'h01);
        wr(WINDOW_ADDR, 8'h00);
        @(posedge clk);
        extBit <= 8'h81;
        wr(WAKE_ADDR, 8'h01);
        wr(CONTROL_ADDR, 8'h1b);
        wr(WINDOW_ADDR, 8'h8e);
        idle(12);
        chk({7'h00, irqReq}, 8'h00);
        rd_chk(WINDOW_ADDR, 8'h8e);
        wr(CONTROL_ADDR, 8'h1a);
        wr(WINDOW_ADDR, 8'h0f);
        idle(12);
        chk({7'h00, irqReq}, 8'h01);
        chk({7'h00, wakeReq}, 8'h01);
        rd_chk(CONTROL_ADDR, 8'h5a);
        wr(WINDOW_ADDR, 8'hff);
        idle(12);
        chk({7'h00, irqReq}, 8'h01);
        wr(CONTROL_ADDR, 8'h18);
        rd(WINDOW_ADDR, d);
        idle(12);
        chk({7'h00, irqReq}, 8'h00);
        chk({7'h00, wakeReq}, 8'h00);
        wr(WAKE_ADDR, 8'h03);
        wr(CONTROL_ADDR, 8'h1a);
        wr(WINDOW_ADDR, 8'h0f);
        idle(12);
        chk({7'h00, irqReq}, 8'h00);
        chk({7'h00, wakeReq}, 8'h01);
        rd_chk(WAKE_ADDR, 8'h03);
    endtask : test_match

    // Event mode with a partial mask
    task test_event;
        logic [7:0] d;
        @(posedge clk);
        extBit <= 8'h00;
        clear_all();
        wr(CONTROL_ADDR, 8'h12);
        wr(WINDOW_ADDR, 8'h0f);
        idle(12);
        wr(CONTROL_ADDR, 8'h10);
        rd(WINDOW_ADDR, d);
        idle(12);
        chk({7'h00, irqReq}, 8'h00);
        @(posedge clk);
        extBit <= 8'h05;
        idle(12);
        chk({7'h00, irqReq}, 8'h00);
        @(posedge clk);
        extBit <= 8'h85;
        idle(12);
        chk({7'h00, irqReq}, 8'h01);
        rd_chk(CONTROL_ADDR, 8'h50);
        wr(CONTROL_ADDR, 8'h13);
        rd_chk(WINDOW_ADDR, 8'h85);
    endtask : test_event

    // Strobe capture, lock-out and re-arm; compare read before clear
    task test_strobe;
        logic [7:0] d;
        clear_all();
        wr(CONTROL_ADDR, 8'h08);
        @(posedge clk);
        extBit <= 8'h3c;
        idle(4);
        pulse();
        chk({7'h00, irqReq}, 8'h01);
        @(posedge clk);
        extBit <= 8'hc3;
        idle(4);
        pulse();
        wr(CONTROL_ADDR, 8'h0b);
        rd_chk(WINDOW_ADDR, 8'h3c);
        wr(CONTROL_ADDR, 8'h08);
        rd(WINDOW_ADDR, d);
        idle(2);
        chk({7'h00, irqReq}, 8'h00);
        pulse();
        chk({7'h00, irqReq}, 8'h01);
        wr(CONTROL_ADDR, 8'h0b);
        rd_chk(WINDOW_ADDR, 8'hc3);
    endtask : test_strobe

    // Standby sampling is slow; wake raised with the interrupt masked
    task test_standby;
        logic [7:0] d;
        clear_all();
        wr(CONTROL_ADDR, 8'h10);
        idle(12);
        rd(WINDOW_ADDR, d);
        wr(WAKE_ADDR, 8'h03);
        @(posedge clk);
        standby <= 1'b1;
        idle(4);
        @(posedge clk);
        extBit <= 8'h3c;
        idle(100);
        chk({7'h00, wakeReq}, 8'h00);
        idle(700);
        chk({7'h00, wakeReq}, 8'h01);
        chk({7'h00, irqReq}, 8'h00);
        @(posedge clk);
        standby <= 1'b0;
        idle(4);
    endtask : test_standby

    // Counts and verdict
    task close_out;
        $display("Comparisons %0d, mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out

    // Main sequence
    initial begin
        clk       = 1'b0;
        srst      = 1'b1;
        ioReq     = '0;
        standby   = 1'b0;
        extBit    = 8'h00;
        extByte   = 8'h00;
        extStrobe = 1'b0;
        err_count = 0;
        checks    = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        idle(2);
        test_ports();
        test_match();
        test_event();
        test_strobe();
        test_standby();
        close_out();
    end

    // Watchdog, far beyond the expected 1200 or so cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        $display("ERROR %0t: watchdog expired", $time);
        close_out();
    end
endmodule : testbench
